/* File: spc_pkg.sv */
/*
  Constants for the switch port control register bank: offsets, field
  positions, reset values, byte counts and ingress limit modes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package spc_pkg;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses on the host register port)
  // ---------------------------------------------------------------
  localparam logic [11:0] CTL2_OFS = 12'h06e;
  localparam logic [11:0] TAG_OFS  = 12'h070;
  localparam logic [11:0] CTL3_OFS = 12'h072;

  // ---------------------------------------------------------------
  // Second control register fields
  // ---------------------------------------------------------------
  localparam int VLAN_FILT_BIT = 14;
  localparam int NON_PORT_DEFAULT_VLAN_ID_BIT  = 13;
  localparam int FORCE_FC_BIT  = 12;
  localparam int BACKPR_BIT    = 11;
  localparam int TX_EN_BIT     = 10;
  localparam int RX_EN_BIT     = 9;
  localparam int LEARN_DIS_BIT = 8;
  localparam int SNIFFER_BIT   = 7;
  localparam int RX_SNIFF_BIT  = 6;
  localparam int TX_SNIFF_BIT  = 5;
  localparam int CEILING_BIT   = 3;
  localparam logic [15:0] CTL2_RW_MASK = 16'hfff0;
  localparam logic [15:0] CTL2_RST     = 16'h0600;

  // ---------------------------------------------------------------
  // Default tag and third control register fields
  // ---------------------------------------------------------------
  localparam int PRIO_MSB = 15;
  localparam int PRIO_LSB = 13;
  localparam int CFI_BIT  = 12;
  localparam logic [15:0] TAG_RST      = 16'h0001;
  localparam int LIMIT_MSB = 3;
  localparam int LIMIT_LSB = 2;
  localparam int IFG_BIT   = 1;
  localparam int PRE_BIT   = 0;
  localparam logic [15:0] CTL3_RW_MASK = 16'h001f;
  localparam logic [15:0] CTL3_RST     = 16'h0000;

  // ---------------------------------------------------------------
  // Byte counts added to rate calculations
  // ---------------------------------------------------------------
  localparam logic [11:0] IFG_BYTES = 12'h00c;
  localparam logic [11:0] PRE_BYTES = 12'h008;

  // Ingress limit modes
  typedef enum logic [1:0] {
    LIM_ALL   = 2'h0,
    LIM_FLOOD = 2'h1,
    LIM_MULTI = 2'h2,
    LIM_BCAST = 2'h3
  } spc_limit_t;
endpackage : spc_pkg

/* File: spc_pkt_decide.sv */
/*
  Per-packet ingress decision for one switch port: drop, VLAN id,
  priority ceiling, learning, monitoring, membership and rate count.
  Assumes configuration fields are stable register outputs.
*/
`timescale 1ns/100ps
module spc_pkt_decide #(
  parameter int PORT_BIT = 0
) (
  input  wire logic        clock,        // Core clock
  input  wire logic        sys_rst,      // Sync reset
  input  wire logic        clkEn,        // Freeze when low
  input  wire logic [15:0] ctl2,         // Second control
  input  wire logic [15:0] dfltTag,      // Default tag
  input  wire logic [15:0] ctl3,         // Third control
  input  wire logic        rxStart,      // Packet header valid
  input  wire logic        rxTagged,     // Packet has a tag
  input  wire logic [11:0] rxVid,        // Packet VLAN id
  input  wire logic [2:0]  rxPrio,       // Packet priority
  input  wire logic [2:0]  rxVlanMembers, // VLAN table members
  input  wire logic        rxBcast,      // Broadcast frame
  input  wire logic        rxMcast,      // Multicast frame
  input  wire logic        rxFlood,      // Flooded unicast
  input  wire logic [10:0] rxLen,        // Frame length
  output logic             inDone_reg,   // Decision pulse
  output logic             inDrop_reg,   // Discard packet
  output logic [11:0]      inVid_reg,    // Assigned VLAN id
  output logic [2:0]       inPrio_reg,   // Final priority
  output logic             inLearn_reg,  // Learn source address
  output logic             inMonitor_reg, // Monitored packet
  output logic [2:0]       inFwdMask_reg, // Allowed egress ports
  output logic             inLimited_reg, // Counted by limiter
  output logic [11:0]      inCountLen_reg // Counted length
);
  // ---------------------------------------------------------------
  // Decision terms
  // ---------------------------------------------------------------
  // Untagged or null-id packets take the port default id
  wire logic        useDflt = !rxTagged || rxVid == 12'h000;
  wire logic [11:0] effVid  = useDflt ? dfltTag[11:0] : rxVid;
  wire logic        filtDrop = ctl2[spc_pkg::VLAN_FILT_BIT] &&
                               !rxVlanMembers[PORT_BIT];
  wire logic        pvidDrop = ctl2[spc_pkg::NON_PORT_DEFAULT_VLAN_ID_BIT] &&
                               effVid != dfltTag[11:0];
  wire logic        drop     = !ctl2[spc_pkg::RX_EN_BIT] ||
                               filtDrop || pvidDrop;
  wire logic [2:0]  userPrio = dfltTag[spc_pkg::PRIO_MSB:spc_pkg::PRIO_LSB];
  wire logic        capPrio  = ctl2[spc_pkg::CEILING_BIT] && rxPrio > userPrio;
  wire logic [2:0]  prio     = capPrio ? userPrio : rxPrio;
  wire spc_pkg::spc_limit_t mode;
  assign mode = spc_pkg::spc_limit_t'(ctl3[spc_pkg::LIMIT_MSB:spc_pkg::LIMIT_LSB]);
  logic limited;
  // Frame class selection by limit mode
  always_comb begin
    unique case (mode)
      spc_pkg::LIM_ALL:   limited = 1'b1;
      spc_pkg::LIM_FLOOD: limited = rxBcast || rxMcast || rxFlood;
      spc_pkg::LIM_MULTI: limited = rxBcast || rxMcast;
      spc_pkg::LIM_BCAST: limited = rxBcast;
    endcase
  end
  wire logic [11:0] ifgAdd = ctl3[spc_pkg::IFG_BIT] ? spc_pkg::IFG_BYTES : 12'h000;
  wire logic [11:0] preAdd = ctl3[spc_pkg::PRE_BIT] ? spc_pkg::PRE_BYTES : 12'h000;
  wire logic [11:0] cntLen = {1'b0, rxLen} + ifgAdd + preAdd;

  // ---------------------------------------------------------------
  // Registered decision, sampled per packet so edits hit the next one
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inDone_reg     <= 1'b0;
      inDrop_reg     <= 1'b0;
      inVid_reg      <= 12'h000;
      inPrio_reg     <= 3'h0;
      inLearn_reg    <= 1'b0;
      inMonitor_reg  <= 1'b0;
      inFwdMask_reg  <= 3'h0;
      inLimited_reg  <= 1'b0;
      inCountLen_reg <= 12'h000;
    end else if (clkEn) begin
      inDone_reg <= rxStart;
      if (rxStart) begin
        inDrop_reg     <= drop;
        inVid_reg      <= effVid;
        inPrio_reg     <= prio;
        inLearn_reg    <= !drop && !ctl2[spc_pkg::LEARN_DIS_BIT];
        inMonitor_reg  <= !drop && ctl2[spc_pkg::RX_SNIFF_BIT];
        inFwdMask_reg  <= ctl2[2:0] & ~(3'h1 << PORT_BIT);
        inLimited_reg  <= limited;
        inCountLen_reg <= cntLen;
      end
    end
  end
endmodule : spc_pkt_decide

/* File: spc_port_regs.sv */
/*
  Control register bank for one switch port with its packet-level
  effects: enables, flow control, mirroring and ingress decisions.
  Assumes a 16-bit host register port with byte enables and
  packet header strobes synchronous to the core clock.
*/
`timescale 1ns/100ps

// Overview of operation
// - Ingress filtering drops packets whose VLAN members exclude this port.
// - Discard packets whose VLAN id differs from the port default id.
// - Forced flow control overrides the negotiated result.
// - Back pressure bit enables half-duplex back pressure.
// - Transmit enable resets to one; clearing it stops sending.
// - Receive enable resets to one; clearing it refuses packets.
// - Learning disable suppresses source address learning.
// - Sniffer bit makes this port the mirror destination.
// - Receive sniff marks received packets monitored.
// - Transmit sniff marks transmitted packets monitored.
// - Read-only ceiling caps packet priority at the default user priority.
// - Default tag holds priority, CFI and VLAN id resetting to one.
// - Default tag gives id to untagged packets, lookup and egress tags.
// - Limit mode selects which frame classes are counted.
// - Gap bit adds twelve bytes per frame to rate counts.
// - Preamble bit adds eight bytes per frame to rate counts.
// - Inserted egress tag carries the ingress default id; tagged unchanged.
module spc_port_regs #(
  parameter logic [2:0] MEMBERSHIP = 3'h7, // Read-only member strap
  parameter logic       CEILING    = 1'b0, // Read-only ceiling strap
  parameter int         PORT_BIT   = 0     // This port in member masks
) (
  input  wire logic        clock,         // Core clock, 100 MHz
  input  wire logic        sys_rst,       // Sync reset, active high
  input  wire logic        clkEn,         // Freeze all state when low
  input  wire logic [11:0] regAddr,       // Byte address
  input  wire logic [15:0] regWrData,     // Write data
  input  wire logic [1:0]  regByteEn,     // Byte enables
  input  wire logic        regWrite,      // Write strobe
  input  wire logic        regRead,       // Read strobe
  input  wire logic        negFlowCtl,    // Negotiated flow control
  input  wire logic        rxStart,       // Ingress header valid
  input  wire logic        rxTagged,      // Ingress has a tag
  input  wire logic [11:0] rxVid,         // Ingress VLAN id
  input  wire logic [2:0]  rxPrio,        // Ingress priority
  input  wire logic [2:0]  rxVlanMembers, // VLAN table members
  input  wire logic        rxBcast,       // Broadcast frame
  input  wire logic        rxMcast,       // Multicast frame
  input  wire logic        rxFlood,       // Flooded unicast
  input  wire logic [10:0] rxLen,         // Ingress length
  input  wire logic        txStart,       // Egress header valid
  input  wire logic        txTagged,      // Egress has a tag
  input  wire logic        txMonitored,   // Packet marked monitored
  input  wire logic        tagInsertEn,   // Egress insertion enabled
  input  wire logic [15:0] txSrcTag,      // Ingress port default tag
  input  wire logic [10:0] txLen,         // Egress length
  output logic [15:0]      regRdData_reg, // Read data
  output logic             regRdValid_reg, // Read data valid
  output logic             txEnable_reg,  // Port may transmit
  output logic             rxEnable_reg,  // Port may receive
  output logic             flowCtl_reg,   // Flow control active
  output logic             backPress_reg, // Half-duplex back pressure
  output logic             sniffer_reg,   // Mirror destination
  output logic             inDone_reg,    // Ingress decision pulse
  output logic             inDrop_reg,    // Drop ingress packet
  output logic [11:0]      inVid_reg,     // Assigned VLAN id
  output logic [2:0]       inPrio_reg,    // Final priority
  output logic             inLearn_reg,   // Learn source address
  output logic             inMonitor_reg, // Copy to mirror port
  output logic [2:0]       inFwdMask_reg, // Allowed egress ports
  output logic             inLimited_reg, // Counted by limiter
  output logic [11:0]      inCountLen_reg, // Counted ingress length
  output logic             txDone_reg,    // Egress decision pulse
  output logic             txSend_reg,    // Send the packet
  output logic             txMirror_reg,  // Copy to mirror port
  output logic             txInsert_reg,  // Insert a tag
  output logic [15:0]      txTag_reg,     // Tag to insert
  output logic [11:0]      txCountLen_reg // Counted egress length
);
  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (PORT_BIT < 0 || PORT_BIT > 2) begin : g_bad_port
    $error("PORT_BIT must lie in 0..2");
  end

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [15:0] ctl2_reg;
  logic [15:0] tag_reg;
  logic [15:0] ctl3_reg;

  // Address decode and byte-lane write masks
  wire logic        hitCtl2 = regAddr == spc_pkg::CTL2_OFS;
  wire logic        hitTag  = regAddr == spc_pkg::TAG_OFS;
  wire logic        hitCtl3 = regAddr == spc_pkg::CTL3_OFS;
  wire logic [15:0] laneMask = {{8{regByteEn[1]}}, {8{regByteEn[0]}}};
  wire logic        wrEn = regWrite && clkEn;

  // Read-only fields are overlaid, so they never hold written values
  wire logic [15:0] ctl2View = (ctl2_reg & spc_pkg::CTL2_RW_MASK) |
                               {12'h000, CEILING, MEMBERSHIP};
  wire logic [15:0] ctl3View = ctl3_reg & spc_pkg::CTL3_RW_MASK;

  wire logic [15:0] ctl2_next = (ctl2_reg & ~laneMask) | (regWrData & laneMask);
  wire logic [15:0] tag_next  = (tag_reg & ~laneMask) | (regWrData & laneMask);
  wire logic [15:0] ctl3_next = (ctl3_reg & ~laneMask) | (regWrData & laneMask);

  wire logic [15:0] rdMux = hitCtl2 ? ctl2View :
                            hitTag  ? tag_reg  :
                            hitCtl3 ? ctl3View : 16'h0000;

  // Register writes; fields steer logic on the next packet
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctl2_reg <= spc_pkg::CTL2_RST;
      tag_reg  <= spc_pkg::TAG_RST;
      ctl3_reg <= spc_pkg::CTL3_RST;
    end else if (wrEn) begin
      if (hitCtl2) ctl2_reg <= ctl2_next;
      if (hitTag)  tag_reg  <= tag_next;
      if (hitCtl3) ctl3_reg <= ctl3_next;
    end
  end

  // Read path; unmapped addresses read as zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regRdData_reg  <= 16'h0000;
      regRdValid_reg <= 1'b0;
    end else if (clkEn) begin
      regRdValid_reg <= regRead;
      if (regRead) regRdData_reg <= rdMux;
    end
  end

  // ---------------------------------------------------------------
  // Port-level controls, one cycle behind the register
  // ---------------------------------------------------------------
  wire logic fcNext = ctl2_reg[spc_pkg::FORCE_FC_BIT] || negFlowCtl;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txEnable_reg  <= 1'b1;
      rxEnable_reg  <= 1'b1;
      flowCtl_reg   <= 1'b0;
      backPress_reg <= 1'b0;
      sniffer_reg   <= 1'b0;
    end else if (clkEn) begin
      txEnable_reg  <= ctl2_reg[spc_pkg::TX_EN_BIT];
      rxEnable_reg  <= ctl2_reg[spc_pkg::RX_EN_BIT];
      flowCtl_reg   <= fcNext;
      backPress_reg <= ctl2_reg[spc_pkg::BACKPR_BIT];
      sniffer_reg   <= ctl2_reg[spc_pkg::SNIFFER_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Ingress decision
  // ---------------------------------------------------------------
  spc_pkt_decide #(
    .PORT_BIT (PORT_BIT)
  ) u_decide (
    .clock          (clock),
    .sys_rst        (sys_rst),
    .clkEn          (clkEn),
    .ctl2           (ctl2View),
    .dfltTag        (tag_reg),
    .ctl3           (ctl3View),
    .rxStart        (rxStart),
    .rxTagged       (rxTagged),
    .rxVid          (rxVid),
    .rxPrio         (rxPrio),
    .rxVlanMembers  (rxVlanMembers),
    .rxBcast        (rxBcast),
    .rxMcast        (rxMcast),
    .rxFlood        (rxFlood),
    .rxLen          (rxLen),
    .inDone_reg     (inDone_reg),
    .inDrop_reg     (inDrop_reg),
    .inVid_reg      (inVid_reg),
    .inPrio_reg     (inPrio_reg),
    .inLearn_reg    (inLearn_reg),
    .inMonitor_reg  (inMonitor_reg),
    .inFwdMask_reg  (inFwdMask_reg),
    .inLimited_reg  (inLimited_reg),
    .inCountLen_reg (inCountLen_reg)
  );

  // ---------------------------------------------------------------
  // Egress decision
  // ---------------------------------------------------------------
  wire logic        txOk    = ctl2_reg[spc_pkg::TX_EN_BIT];
  // A port with transmit enabled and transmit sniff set sends mirror copies as well as its own traffic
  wire logic        txMir   = txOk && ctl2_reg[spc_pkg::TX_SNIFF_BIT];
  wire logic        txIns   = tagInsertEn && !txTagged;
  wire logic [11:0] txIfg   = ctl3_reg[spc_pkg::IFG_BIT] ? spc_pkg::IFG_BYTES : 12'h000;
  wire logic [11:0] txPre   = ctl3_reg[spc_pkg::PRE_BIT] ? spc_pkg::PRE_BYTES : 12'h000;
  wire logic [11:0] txCnt   = {1'b0, txLen} + txIfg + txPre;
  wire logic        txGoNext = txOk && (!txMonitored || ctl2_reg[spc_pkg::SNIFFER_BIT] ||
                                        1'b1);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      txDone_reg     <= 1'b0;
      txSend_reg     <= 1'b0;
      txMirror_reg   <= 1'b0;
      txInsert_reg   <= 1'b0;
      txTag_reg      <= 16'h0000;
      txCountLen_reg <= 12'h000;
    end else if (clkEn) begin
      txDone_reg <= txStart;
      if (txStart) begin
        txSend_reg     <= txGoNext;
        txMirror_reg   <= txMir;
        txInsert_reg   <= txIns;
        txTag_reg      <= txIns ? txSrcTag : 16'h0000;
        txCountLen_reg <= txCnt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_rx(cond);
    clkEn && rxStart && cond;
  endsequence

  filter_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_rx(ctl2_reg[spc_pkg::VLAN_FILT_BIT] && !rxVlanMembers[PORT_BIT])
    |=> inDone_reg && inDrop_reg)
    else $error("filtered packet not dropped");

  port_default_vlan_id_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_rx(ctl2_reg[spc_pkg::NON_PORT_DEFAULT_VLAN_ID_BIT] && rxTagged && rxVid != 12'h000 &&
         rxVid != tag_reg[11:0]) |=> inDrop_reg)
    else $error("non default id packet kept");

  force_fc_a: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && ctl2_reg[spc_pkg::FORCE_FC_BIT] |=> flowCtl_reg)
    else $error("forced flow control inactive");

  rx_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_rx(!ctl2_reg[spc_pkg::RX_EN_BIT]) |=> inDrop_reg && !inLearn_reg)
    else $error("packet taken while receive off");

  tx_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && txStart && !ctl2_reg[spc_pkg::TX_EN_BIT] |=> txDone_reg && !txSend_reg)
    else $error("packet sent while transmit off");

  learn_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_rx(ctl2_reg[spc_pkg::LEARN_DIS_BIT]) |=> !inLearn_reg)
    else $error("learning while disabled");

  prio_cap_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_rx(CEILING) |=> inPrio_reg <= tag_reg[spc_pkg::PRIO_MSB:spc_pkg::PRIO_LSB] ||
                      $past(tag_reg) != tag_reg)
    else $error("priority above ceiling");

  dflt_vid_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_rx(!rxTagged) ##1 1'b1 |-> inVid_reg == $past(tag_reg[11:0]))
    else $error("untagged packet missed default id");

  count_len_a: assert property (@(posedge clock) disable iff (sys_rst)
    s_rx(ctl3_reg[1:0] == 2'h3) |=> inCountLen_reg == 12'(($past(rxLen)) + 11'd20))
    else $error("counted length wrong");

  tag_ins_a: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && txStart && txTagged |=> !txInsert_reg && txTag_reg == 16'h0000)
    else $error("tag inserted on tagged packet");
endmodule : spc_port_regs

/* File: spc_port_regs_test.sv */
/*
  Self-checking bench for spc_port_regs: register access, port levels,
  ingress and egress decisions under random traffic.
  Assumes default straps: MEMBERSHIP 3'h7, CEILING 0, PORT_BIT 0.
*/
`timescale 1ns/100ps
module spc_port_regs_test;
  logic        clock, sys_rst, clkEn, regWrite, regRead, negFlowCtl;
  logic [11:0] regAddr, rxVid, inVid_reg, inCountLen_reg, txCountLen_reg;
  logic [15:0] regWrData, txSrcTag, regRdData_reg, txTag_reg, c2, tg, c3;
  logic [1:0]  regByteEn;
  logic        rxStart, rxTagged, rxBcast, rxMcast, rxFlood;
  logic        txStart, txTagged, txMonitored, tagInsertEn;
  logic [2:0]  rxPrio, rxVlanMembers, inPrio_reg, inFwdMask_reg;
  logic [10:0] rxLen, txLen;
  logic        regRdValid_reg, txEnable_reg, rxEnable_reg, flowCtl_reg;
  logic        backPress_reg, sniffer_reg, inDone_reg, inDrop_reg, inLearn_reg;
  logic        inMonitor_reg, inLimited_reg, txDone_reg, txSend_reg;
  logic        txMirror_reg, txInsert_reg;
  int          n_errors, checked, seed, i;
  logic [11:0] adr [4];

  spc_port_regs u_dut (.*);

  // Free-running core clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // -------------------------------------------------------------
  // Shared tasks and expectation functions
  // -------------------------------------------------------------
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Shadows track byte lanes so expectations never come from the design
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    regAddr = a; regWrData = d; regByteEn = be; regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
    if (a == spc_pkg::CTL2_OFS) c2 = (c2 & ~m) | (d & m);
    if (a == spc_pkg::TAG_OFS) tg = (tg & ~m) | (d & m);
    if (a == spc_pkg::CTL3_OFS) c3 = (c3 & ~m) | (d & m);
  endtask : wr

  function automatic logic [15:0] rexp(input logic [11:0] a);
    if (a == spc_pkg::CTL2_OFS) return (c2 & spc_pkg::CTL2_RW_MASK) | 16'h0007;
    if (a == spc_pkg::TAG_OFS) return tg;
    if (a == spc_pkg::CTL3_OFS) return c3 & spc_pkg::CTL3_RW_MASK;
    return 16'h0000;
  endfunction : rexp

  task automatic rd(input logic [11:0] a);
    regAddr = a; regRead = 1'b1;
    @(negedge clock);
    regRead = 1'b0;
    chk(regRdValid_reg, 1'b1);
    chk(regRdData_reg, rexp(a));
  endtask : rd

  function automatic logic [33:0] iexp();
    logic [11:0] v;
    logic        d, l;
    v = (!rxTagged || rxVid == 12'h000) ? tg[11:0] : rxVid;
    d = !c2[9] || (c2[14] && !rxVlanMembers[0]) || (c2[13] && v != tg[11:0]);
    case (c3[3:2])
      2'h0: l = 1'b1;
      2'h1: l = rxBcast | rxMcast | rxFlood;
      2'h2: l = rxBcast | rxMcast;
      default: l = rxBcast;
    endcase
    return {d, v, rxPrio, !d && !c2[8], !d && c2[6], 3'h6, l,
            {1'b0, rxLen} + (c3[1] ? 12'h00c : 12'h000) + (c3[0] ? 12'h008 : 12'h000)};
  endfunction : iexp

  // Hang guard sized well beyond the expected run
  initial begin
    #100000;
    n_errors++;
    results();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    seed = 57;
    adr = '{spc_pkg::CTL2_OFS, spc_pkg::TAG_OFS, spc_pkg::CTL3_OFS, 12'h074};
    {regWrite, regRead, negFlowCtl, rxStart, rxTagged, rxBcast, rxMcast} = '0;
    {rxFlood, txStart, txTagged, txMonitored, tagInsertEn} = '0;
    {regAddr, rxVid, regWrData, txSrcTag, regByteEn} = '0;
    {rxPrio, rxVlanMembers, rxLen, txLen} = '0;
    clkEn = 1'b1;
    sys_rst = 1'b1;
    c2 = spc_pkg::CTL2_RST;
    tg = spc_pkg::TAG_RST;
    c3 = spc_pkg::CTL3_RST;
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    foreach (adr[k]) rd(adr[k]);
    chk({txEnable_reg, rxEnable_reg, flowCtl_reg}, 3'h6);
    // Corner: read-only straps and upper-lane only write
    wr(spc_pkg::CTL2_OFS, 16'h000f, 2'h1);
    rd(spc_pkg::CTL2_OFS);
    wr(spc_pkg::TAG_OFS, 16'h2005, 2'h2);
    rd(spc_pkg::TAG_OFS);
    for (i = 0; i < 300; i++) begin
      negFlowCtl = $random(seed);
      wr(adr[i % 4], $random(seed), (i % 5 == 0) ? 2'h3 : 2'($random(seed)));
      @(negedge clock);
      chk({txEnable_reg, rxEnable_reg, flowCtl_reg, backPress_reg, sniffer_reg},
          {c2[10], c2[9], c2[12] | negFlowCtl, c2[11], c2[7]});
      rd(adr[($random(seed) & 3)]);
      {rxTagged, rxBcast, rxMcast, rxFlood, txTagged, tagInsertEn} = $random(seed);
      {rxPrio, rxVlanMembers, rxLen} = $random(seed);
      rxVid = (i % 6 == 0) ? 12'h000 : (i % 6 == 1) ? tg[11:0] : 12'($random(seed));
      {txMonitored, txLen} = $random(seed);
      txSrcTag = $random(seed);
      rxStart = 1'b1;
      txStart = 1'b1;
      @(negedge clock);
      rxStart = 1'b0;
      txStart = 1'b0;
      chk({inDone_reg, txDone_reg}, 2'h3);
      chk({inDrop_reg, inVid_reg, inPrio_reg, inLearn_reg, inMonitor_reg, inFwdMask_reg,
           inLimited_reg, inCountLen_reg}, iexp());
      chk({txSend_reg, txMirror_reg, txInsert_reg, txTag_reg, txCountLen_reg},
          {c2[10], c2[10] & c2[5], tagInsertEn & !txTagged,
           (tagInsertEn & !txTagged) ? txSrcTag : 16'h0000,
           {1'b0, txLen} + (c3[1] ? 12'h00c : 12'h000) + (c3[0] ? 12'h008 : 12'h000)});
    end
    // Corner: a write while the clock enable is low must be ignored
    regAddr = spc_pkg::TAG_OFS; regWrData = 16'hffff; regByteEn = 2'h3;
    regWrite = 1'b1;
    clkEn = 1'b0;
    @(negedge clock);
    regWrite = 1'b0;
    clkEn = 1'b1;
    rd(spc_pkg::TAG_OFS);
    results();
  end
endmodule : spc_port_regs_test
